//--- logic/dotr_pkg.sv
/*
 package for the drive output terminal router: register byte addresses, field layout,
 reset values, selection codes, timing constants and the drive status carrier.
 assumes a 125 MHz control clock and a plain byte-addressed register port.
*/
package dotr_pkg;
   // terminals: 0 fast, 1 first relay, 2 second relay, 3 open collector, 4 extension
   localparam int NUM_TERM = 5;
   localparam int SEL_W    = 6;
   localparam int DLY_W    = 16;
   localparam int VAL_W    = 16;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;

   // register byte addresses, one aligned word each
   localparam logic [7:0] REG_MODE   = 8'h00;
   localparam logic [7:0] REG_SEL0   = 8'h04;
   localparam logic [7:0] REG_POL    = 8'h18;
   localparam logic [7:0] REG_DLY0   = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h30;
   localparam logic [7:0] REG_STEP   = 8'h04;

   // fast terminal mode values
   localparam logic MODE_PULSE  = 1'b0;
   localparam logic MODE_SWITCH = 1'b1;

   // reset values of selections, polarity and delays
   localparam logic [SEL_W-1:0] SEL_RST [NUM_TERM] = '{6'h00, 6'h02, 6'h00, 6'h01, 6'h00};
   localparam logic [NUM_TERM-1:0] POL_RST = 5'h00;
   localparam logic [DLY_W-1:0]    DLY_RST = 16'h0000;
   localparam logic [DLY_W-1:0]    DLY_MAX = 16'h8CA0;   // 3600.0 s in 0.1 s steps

   // selection codes
   localparam logic [SEL_W-1:0] SEL_NONE    = 6'h00;
   localparam logic [SEL_W-1:0] SEL_FREQ    = 6'h01;
   localparam logic [SEL_W-1:0] SEL_LEVEL   = 6'h02;
   localparam logic [SEL_W-1:0] SEL_FAULT   = 6'h03;
   localparam logic [SEL_W-1:0] SEL_MOT_OVL = 6'h04;
   localparam logic [SEL_W-1:0] SEL_DRV_OVL = 6'h05;
   localparam logic [SEL_W-1:0] SEL_ZERO1   = 6'h06;
   localparam logic [SEL_W-1:0] SEL_ZERO2   = 6'h07;
   localparam logic [SEL_W-1:0] SEL_UPPER   = 6'h08;
   localparam logic [SEL_W-1:0] SEL_LOWER   = 6'h09;
   localparam logic [SEL_W-1:0] SEL_CNT_SET = 6'h0A;
   localparam logic [SEL_W-1:0] SEL_CNT_DES = 6'h0B;
   localparam logic [SEL_W-1:0] SEL_LENGTH  = 6'h0C;
   localparam logic [SEL_W-1:0] SEL_SEQ     = 6'h0D;
   localparam logic [SEL_W-1:0] SEL_RUNTIME = 6'h0E;
   localparam logic [SEL_W-1:0] SEL_FLIMIT  = 6'h0F;
   localparam logic [SEL_W-1:0] SEL_TORQUE  = 6'h10;
   localparam logic [SEL_W-1:0] SEL_READY   = 6'h11;
   localparam logic [SEL_W-1:0] SEL_RUNNING = 6'h12;
   localparam logic [SEL_W-1:0] SEL_AI_CMP  = 6'h13;
   localparam logic [SEL_W-1:0] SEL_UNDERV  = 6'h14;
   localparam logic [SEL_W-1:0] SEL_MAX     = 6'h28;

   // timing
   localparam longint CLK_HZ       = 125_000_000;
   localparam longint DLY_UNIT_MS  = 100;
   localparam longint SEQ_PULSE_MS = 250;
   localparam longint OVL_LEAD_S   = 10;
   localparam int TICK_CYC      = int'(CLK_HZ / 1000 * DLY_UNIT_MS);
   localparam int SEQ_PULSE_CYC = int'(CLK_HZ / 1000 * SEQ_PULSE_MS);
   localparam logic [VAL_W-1:0] OVL_LEAD_TICKS = VAL_W'(OVL_LEAD_S * 1000 / DLY_UNIT_MS);

   // drive status from the control core, same clock
   typedef struct packed {
      logic             running;
      logic             fault_stop;
      logic             freq_reached;
      logic             freq_level_detect_one;
      logic             speed_mode;
      logic             torque_at_limit;
      logic             stall_active;
      logic             main_stable;
      logic             ctrl_stable;
      logic             undervolt;
      logic             seq_cycle_done;
      logic             drv_ovl_eta_valid;
      logic [VAL_W-1:0] drv_ovl_eta;
      logic [VAL_W-1:0] mot_load;
      logic [VAL_W-1:0] mot_prewarn;
      logic [VAL_W-1:0] out_freq;
      logic [VAL_W-1:0] set_freq;
      logic [VAL_W-1:0] freq_upper;
      logic [VAL_W-1:0] freq_lower;
      logic [VAL_W-1:0] count_val;
      logic [VAL_W-1:0] count_set;
      logic [VAL_W-1:0] count_des;
      logic [VAL_W-1:0] length_val;
      logic [VAL_W-1:0] length_set;
      logic [VAL_W-1:0] run_time;
      logic [VAL_W-1:0] run_time_set;
      logic signed [VAL_W-1:0] analog_input_one;
      logic signed [VAL_W-1:0] analog_input_two;
   } dotr_status_t;
endpackage

//--- logic/dotr_router.sv
/*
 drive output terminal router: builds the condition vector from drive status,
 selects one condition per terminal, delays and inverts it, and drives the pins.
 assumes status and the pulse-frequency source come from logic on clk, and that
 the register master follows the one-cycle strobe protocol.
*/
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module dotr_router
   import dotr_pkg::*;
#(
   parameter int TICK_CYC_P      = TICK_CYC,      // cycles per 0.1 s delay step
   parameter int SEQ_PULSE_CYC_P = SEQ_PULSE_CYC  // cycles of the sequencer pulse
) (
   input  wire logic                clk,          // 125 MHz control clock
   input  wire logic                resetn,       // async reset, active low
   input  wire logic [ADDR_W-1:0]   addr,         // register byte address
   input  wire logic [DATA_W-1:0]   wdata,        // write data
   input  wire logic                wr_stb,       // write strobe
   input  wire logic                rd_stb,       // read strobe
   output logic      [DATA_W-1:0]   rdata,        // read data, cycle after rd_stb
   input  wire dotr_status_t        status,       // drive status, same clock
   input  wire logic                pulse_src,    // pulse-frequency waveform
   output logic                     fast_terminal_pulse_mode, // fast pin in pulse mode
   output logic [NUM_TERM-1:0]      term_closed   // 1: terminal connected to common
);

   logic                  mode_q;
   logic [SEL_W-1:0]      sel_q [NUM_TERM];
   logic [NUM_TERM-1:0]   pol_q;
   logic [DLY_W-1:0]      dly_q [NUM_TERM];
   logic [63:0]           cond;
   logic [NUM_TERM-1:0]   raw;
   logic [NUM_TERM-1:0]   act_q;
   logic [31:0]           tick_cnt_q;
   logic                  tick;
   logic [31:0]           seq_cnt_q;
   logic                  seq_done_q;
   dotr_status_t          s;

   assign s = status;

   // register writes; index is the word offset from the group base
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= MODE_PULSE;
         pol_q  <= POL_RST;
         for (int i = 0; i < NUM_TERM; i++) begin
            sel_q[i] <= SEL_RST[i];
            dly_q[i] <= DLY_RST;
         end
      end else if (wr_stb) begin
         if (addr == REG_MODE) begin
            mode_q <= wdata[0];
         end
         if (addr == REG_POL) begin
            pol_q <= wdata[NUM_TERM-1:0];
         end
         for (int i = 0; i < NUM_TERM; i++) begin
            if (addr == 8'(REG_SEL0 + REG_STEP * i)) begin
               sel_q[i] <= wdata[SEL_W-1:0];
            end
            // delays above the top of range are clipped rather than refused
            if (addr == 8'(REG_DLY0 + REG_STEP * i)) begin
               dly_q[i] <= (wdata[DLY_W-1:0] > DLY_MAX) ? DLY_MAX : wdata[DLY_W-1:0];
            end
         end
      end
   end

   // register reads; unmapped addresses return zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 32'h0000_0000;
      end else if (rd_stb) begin
         rdata <= 32'h0000_0000;
         if (addr == REG_MODE) begin
            rdata[0] <= mode_q;
         end
         if (addr == REG_POL) begin
            rdata[NUM_TERM-1:0] <= pol_q;
         end
         if (addr == REG_STATUS) begin
            rdata[NUM_TERM-1:0]            <= act_q;
            rdata[NUM_TERM+7:8]            <= term_closed;
            rdata[NUM_TERM+15:16]          <= raw;
         end
         for (int i = 0; i < NUM_TERM; i++) begin
            if (addr == 8'(REG_SEL0 + REG_STEP * i)) begin
               rdata[SEL_W-1:0] <= sel_q[i];
            end
            if (addr == 8'(REG_DLY0 + REG_STEP * i)) begin
               rdata[DLY_W-1:0] <= dly_q[i];
            end
         end
      end
   end

   // 0.1 s step divider shared by all delay counters
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_q <= 32'h0000_0000;
      end else if (tick) begin
         tick_cnt_q <= 32'h0000_0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
   end
   assign tick = (tick_cnt_q == 32'(TICK_CYC_P - 1));

   // sequencer pulse stretcher; a new cycle end restarts the full width
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         seq_done_q <= 1'b0;
         seq_cnt_q  <= 32'h0000_0000;
      end else begin
         seq_done_q <= s.seq_cycle_done;
         if (s.seq_cycle_done && !seq_done_q) begin
            seq_cnt_q <= 32'(SEQ_PULSE_CYC_P);
         end else if (seq_cnt_q != 32'h0000_0000) begin
            seq_cnt_q <= seq_cnt_q - 32'h0000_0001;
         end
      end
   end

   // condition vector, one bit per selection code; unlisted codes stay low
   always_comb begin
      cond = 64'h0000_0000_0000_0000;
      cond[SEL_FREQ]    = s.freq_reached;
      cond[SEL_LEVEL]   = s.freq_level_detect_one;
      cond[SEL_FAULT]   = s.fault_stop;
      cond[SEL_MOT_OVL] = s.mot_load > s.mot_prewarn;
      // eta is the estimated time to trip in 0.1 s steps
      cond[SEL_DRV_OVL] = s.drv_ovl_eta_valid && (s.drv_ovl_eta <= OVL_LEAD_TICKS);
      cond[SEL_ZERO1]   = s.running && (s.out_freq == 16'h0000);
      cond[SEL_ZERO2]   = !s.running || (s.out_freq == 16'h0000);
      cond[SEL_UPPER]   = s.running && (s.out_freq >= s.freq_upper);
      cond[SEL_LOWER]   = s.running && (s.out_freq <= s.freq_lower);
      cond[SEL_CNT_SET] = s.count_val >= s.count_set;
      cond[SEL_CNT_DES] = s.count_val >= s.count_des;
      cond[SEL_LENGTH]  = s.length_val > s.length_set;
      cond[SEL_SEQ]     = seq_cnt_q != 32'h0000_0000;
      cond[SEL_RUNTIME] = s.run_time > s.run_time_set;
      cond[SEL_FLIMIT]  = ((s.set_freq > s.freq_upper) && (s.out_freq >= s.freq_upper)) ||
                          ((s.set_freq < s.freq_lower) && (s.out_freq <= s.freq_lower));
      cond[SEL_TORQUE]  = s.speed_mode && s.torque_at_limit && s.stall_active;
      cond[SEL_READY]   = s.main_stable && s.ctrl_stable && !s.fault_stop;
      cond[SEL_RUNNING] = s.running;
      cond[SEL_AI_CMP]  = s.analog_input_one > s.analog_input_two;
      cond[SEL_UNDERV]  = s.undervolt;
   end

   // per-terminal select and delay
   for (genvar g = 0; g < NUM_TERM; g++) begin : g_term
      logic [DLY_W-1:0] dcnt_q;
      logic             lvl_q;    // delayed level, one process owns it

      assign act_q[g] = lvl_q;

      // code 0 and out-of-range codes pick nothing
      assign raw[g] = (sel_q[g] != SEL_NONE) && (sel_q[g] <= SEL_MAX) &&
                      cond[sel_q[g]];

      // a change must persist until the dly_q[g]-th tick of the shared step divider; a glitch back restarts it
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            lvl_q  <= 1'b0;
            dcnt_q <= 16'h0000;
         end else if (raw[g] == lvl_q) begin
            dcnt_q <= 16'h0000;
         end else if (dly_q[g] == 16'h0000) begin
            lvl_q <= raw[g];
         end else if (tick) begin
            if (dcnt_q + 16'h0001 >= dly_q[g]) begin
               lvl_q  <= raw[g];
               dcnt_q <= 16'h0000;
            end else begin
               dcnt_q <= dcnt_q + 16'h0001;
            end
         end
      end
   end

   // pin stage; polarity does not apply to the pulse waveform
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         term_closed <= 5'h00;
      end else begin
         term_closed <= act_q ^ pol_q;
         if (mode_q == MODE_PULSE) begin
            term_closed[0] <= pulse_src;
         end
      end
   end
   assign fast_terminal_pulse_mode = (mode_q == MODE_PULSE);

   property p_mode;
      @(posedge clk) disable iff (!resetn)
      (mode_q == MODE_PULSE) |=> term_closed[0] == $past(pulse_src);
   endproperty
   a_mode: assert property (p_mode) else $error("pulse mode pin mismatch");

   property p_inactive;
      @(posedge clk) disable iff (!resetn)
      (sel_q[1] == SEL_NONE || sel_q[1] > SEL_MAX) |-> !raw[1];
   endproperty
   a_inactive: assert property (p_inactive) else $error("idle code drives");

   property p_fault;
      @(posedge clk) disable iff (!resetn)
      (sel_q[2] == SEL_FAULT) |-> raw[2] == s.fault_stop;
   endproperty
   a_fault: assert property (p_fault) else $error("fault select wrong");

   property p_zero;
      @(posedge clk) disable iff (!resetn)
      !s.running |-> cond[SEL_ZERO2] && !cond[SEL_ZERO1] && !cond[SEL_LOWER];
   endproperty
   a_zero: assert property (p_zero) else $error("stop state conditions wrong");

   property p_seq;
      @(posedge clk) disable iff (!resetn)
      (s.seq_cycle_done && !seq_done_q) |=> cond[SEL_SEQ] [*8];
   endproperty
   a_seq: assert property (p_seq) else $error("sequencer pulse too short");

   property p_ready;
      @(posedge clk) disable iff (!resetn)
      s.fault_stop |-> !cond[SEL_READY];
   endproperty
   a_ready: assert property (p_ready) else $error("ready with fault");

   property p_pol;
      @(posedge clk) disable iff (!resetn)
      (mode_q == MODE_SWITCH) |=> term_closed == ($past(act_q) ^ $past(pol_q));
   endproperty
   a_pol: assert property (p_pol) else $error("polarity mismatch");

   property p_hold;
      @(posedge clk) disable iff (!resetn)
      (dly_q[3] != 16'h0000 && !tick) |=> act_q[3] == $past(act_q[3]);
   endproperty
   a_hold: assert property (p_hold) else $error("delayed terminal moved");

   property p_nodly;
      @(posedge clk) disable iff (!resetn)
      (dly_q[4] == 16'h0000 && $stable(dly_q[4])) |=> act_q[4] == $past(raw[4]);
   endproperty
   a_nodly: assert property (p_nodly) else $error("zero delay not immediate");

   property p_uv;
      @(posedge clk) disable iff (!resetn)
      cond[SEL_UNDERV] == s.undervolt && cond[SEL_AI_CMP] ==
      (s.analog_input_one > s.analog_input_two);
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage or compare wrong");

   property p_motovl;
      @(posedge clk) disable iff (!resetn)
      (s.mot_load > s.mot_prewarn) |-> cond[SEL_MOT_OVL];
   endproperty
   a_motovl: assert property (p_motovl) else $error("load pre-warning missed");

   property p_drvovl;
      @(posedge clk) disable iff (!resetn)
      (s.drv_ovl_eta_valid && s.drv_ovl_eta <= OVL_LEAD_TICKS) |-> cond[SEL_DRV_OVL];
   endproperty
   a_drvovl: assert property (p_drvovl) else $error("trip lead warning missed");

   property p_zerorun;
      @(posedge clk) disable iff (!resetn)
      (s.running && s.out_freq == 16'h0000) |-> cond[SEL_ZERO1] && cond[SEL_ZERO2];
   endproperty
   a_zerorun: assert property (p_zerorun) else $error("zero speed run missed");

   property p_upper;
      @(posedge clk) disable iff (!resetn)
      (s.running && s.out_freq >= s.freq_upper) |-> cond[SEL_UPPER];
   endproperty
   a_upper: assert property (p_upper) else $error("upper limit missed");

   property p_lower;
      @(posedge clk) disable iff (!resetn)
      (s.running && s.out_freq <= s.freq_lower) |-> cond[SEL_LOWER];
   endproperty
   a_lower: assert property (p_lower) else $error("lower limit missed");

   property p_count;
      @(posedge clk) disable iff (!resetn)
      cond[SEL_CNT_SET] == (s.count_val >= s.count_set) &&
      cond[SEL_CNT_DES] == (s.count_val >= s.count_des);
   endproperty
   a_count: assert property (p_count) else $error("count target wrong");

   property p_length;
      @(posedge clk) disable iff (!resetn)
      (s.length_val > s.length_set) |-> cond[SEL_LENGTH];
   endproperty
   a_length: assert property (p_length) else $error("length target missed");

   property p_runtime;
      @(posedge clk) disable iff (!resetn)
      (s.run_time > s.run_time_set) |-> cond[SEL_RUNTIME];
   endproperty
   a_runtime: assert property (p_runtime) else $error("running time missed");

   property p_flimit;
      @(posedge clk) disable iff (!resetn)
      (s.set_freq > s.freq_upper && s.out_freq >= s.freq_upper) |-> cond[SEL_FLIMIT];
   endproperty
   a_flimit: assert property (p_flimit) else $error("frequency limited missed");

   property p_torque;
      @(posedge clk) disable iff (!resetn)
      !s.speed_mode |-> !cond[SEL_TORQUE];
   endproperty
   a_torque: assert property (p_torque) else $error("torque limit outside speed mode");

   property p_running;
      @(posedge clk) disable iff (!resetn)
      cond[SEL_RUNNING] == s.running;
   endproperty
   a_running: assert property (p_running) else $error("running condition wrong");

   property p_reserved;
      @(posedge clk) disable iff (!resetn)
      (sel_q[0] > SEL_UNDERV) |-> !raw[0];
   endproperty
   a_reserved: assert property (p_reserved) else $error("unbuilt code drives");

   property p_selwr;
      @(posedge clk) disable iff (!resetn)
      (wr_stb && addr == REG_SEL0) |=> sel_q[0] == $past(wdata[SEL_W-1:0]);
   endproperty
   a_selwr: assert property (p_selwr) else $error("selection write lost");

   property p_rdmode;
      @(posedge clk) disable iff (!resetn)
      (rd_stb && addr == REG_MODE) |=> rdata == {31'h0000_0000, $past(mode_q)};
   endproperty
   a_rdmode: assert property (p_rdmode) else $error("mode readback wrong");

   property p_steady;
      @(posedge clk) disable iff (!resetn)
      (raw[2] == act_q[2]) |=> act_q[2] == $past(act_q[2]);
   endproperty
   a_steady: assert property (p_steady) else $error("terminal moved without cause");

   c_mode: cover property (@(posedge clk) disable iff (!resetn) $rose(mode_q));
   c_seq: cover property (@(posedge clk) disable iff (!resetn) $fell(cond[SEL_SEQ]));
   c_dly: cover property (@(posedge clk) disable iff (!resetn)
      tick && dly_q[3] != 16'h0000 && $changed(act_q[3]));
   c_fault: cover property (@(posedge clk) disable iff (!resetn) $rose(term_closed[2]));
   c_rsv: cover property (@(posedge clk) disable iff (!resetn) sel_q[0] > SEL_MAX);

endmodule

//--- tb/dotr_field_loads.sv
/*
 field wiring model: one load on each output terminal, energised while closed.
 assumes term_closed comes from the router; no pull resistors on the contacts.
*/
`timescale 1ns/1ps
module dotr_field_loads
   import dotr_pkg::*;
(
   input  wire logic [NUM_TERM-1:0] closed,  // terminal levels from the router
   output logic      [NUM_TERM-1:0] load_on  // loads energised
);
   // a load follows its contact; coil inertia is ignored since only levels are judged
   assign load_on = closed;
endmodule

//--- tb/tb.sv
/*
 testbench for the output terminal router: register tasks, a reference model
 of the condition table, delay, pulse mode and sequencer pulse cases.
 assumes short tick and pulse parameters so that the run stays small.
*/
`timescale 1ns/1ps
module tb
   import dotr_pkg::*;
;
   localparam int TK = 10;  // cycles per delay step in sim
   localparam int SP = 20;  // sequencer pulse cycles in sim
   logic                clk, resetn, wr_stb, rd_stb, pulse_src, fast_terminal_pulse_mode;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   wdata, rdata, rv;
   logic [NUM_TERM-1:0] term_closed, load_on, pol, cv;
   dotr_status_t        status, s;
   logic [SEL_W-1:0]    sel [NUM_TERM];
   int                  miscompares, checks, cyc, n;

   dotr_router #(.TICK_CYC_P(TK), .SEQ_PULSE_CYC_P(SP)) u_dut (
      .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .status(status), .pulse_src(pulse_src),
      .fast_terminal_pulse_mode(fast_terminal_pulse_mode), .term_closed(term_closed));
   dotr_field_loads u_loads (.closed(term_closed), .load_on(load_on));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (miscompares == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one-cycle strobes; the next call waits an edge so no signal is set twice at once
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 rv = rdata;
   endtask

   // reference condition table, independent of the design's own decode
   function automatic logic ref_cond(logic [SEL_W-1:0] c, dotr_status_t t);
      case (c)
         6'h01: return t.freq_reached;
         6'h02: return t.freq_level_detect_one;
         6'h03: return t.fault_stop;
         6'h04: return t.mot_load > t.mot_prewarn;
         6'h05: return t.drv_ovl_eta_valid && t.drv_ovl_eta <= 16'h0064;
         6'h06: return t.running && t.out_freq == 0;
         6'h07: return !t.running || t.out_freq == 0;
         6'h08: return t.running && t.out_freq >= t.freq_upper;
         6'h09: return t.running && t.out_freq <= t.freq_lower;
         6'h0A: return t.count_val >= t.count_set;
         6'h0B: return t.count_val >= t.count_des;
         6'h0C: return t.length_val > t.length_set;
         6'h0E: return t.run_time > t.run_time_set;
         6'h0F: return (t.set_freq > t.freq_upper && t.out_freq >= t.freq_upper)
                   || (t.set_freq < t.freq_lower && t.out_freq <= t.freq_lower);
         6'h10: return t.speed_mode && t.torque_at_limit && t.stall_active;
         6'h11: return t.main_stable && t.ctrl_stable && !t.fault_stop;
         6'h12: return t.running;
         6'h13: return t.analog_input_one > t.analog_input_two;
         6'h14: return t.undervolt;
         default: return 1'b0;  // code 0, the sequencer code 0x0D, reserved and unbuilt codes
      endcase
   endfunction

   // narrow random values so that equal and boundary cases come up often
   function automatic logic [VAL_W-1:0] r3();
      return VAL_W'($urandom_range(3));
   endfunction

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      {wr_stb, rd_stb, pulse_src, addr, wdata} = '0;
      status = '0;
      resetn = 1'b0;
      void'($urandom(32'h21B6));
      repeat (10) @(posedge clk);
      chk("reset pins", term_closed, 0);
      resetn <= 1'b1;
      // reset values and an unmapped read
      for (int i = 0; i < NUM_TERM; i++) begin
         rd(REG_SEL0 + 8'(4 * i));
         chk("sel reset", rv, 32'(SEL_RST[i]));
         rd(REG_DLY0 + 8'(4 * i));
         chk("dly reset", rv, 32'(DLY_RST));
      end
      rd(REG_POL);
      chk("pol reset", rv, 32'(POL_RST));
      rd(8'h40);
      chk("unmapped", rv, 0);
      chk("pulse mode", fast_terminal_pulse_mode, 1);
      // every code on every terminal, random polarity and status
      wr(REG_MODE, 32'h1);
      #1 chk("switch mode", fast_terminal_pulse_mode, 0);
      rd(REG_MODE);
      chk("mode read", rv, 1);
      for (int k = 0; k < 64; k++) begin
         for (int i = 0; i < NUM_TERM; i++) begin
            sel[i] = SEL_W'(k + 13 * i);
            wr(REG_SEL0 + 8'(4 * i), 32'(sel[i]));
         end
         pol = NUM_TERM'($urandom);
         wr(REG_POL, 32'(pol));
         s = dotr_status_t'({9{$urandom}});
         {s.out_freq, s.set_freq, s.freq_upper, s.freq_lower} = {r3(), r3(), r3(), r3()};
         {s.count_val, s.count_set, s.count_des, s.length_val} = {r3(), r3(), r3(), r3()};
         {s.length_set, s.run_time, s.run_time_set, s.mot_load} = {r3(), r3(), r3(), r3()};
         s.mot_prewarn = r3();
         s.drv_ovl_eta = VAL_W'($urandom_range(102, 98));
         s.analog_input_one = r3() - 16'h0001;
         s.analog_input_two = r3() - 16'h0001;
         s.seq_cycle_done = 1'b0;
         status <= s;
         repeat (3) @(posedge clk);
         for (int i = 0; i < NUM_TERM; i++) begin
            cv[i] = ref_cond(sel[i], s);
         end
         #1 chk("loads", load_on, cv ^ pol);
         rd(REG_STATUS);
         chk("status", rv[20:0], {cv, 3'h0, cv ^ pol, 3'h0, cv});
      end
      // delayed terminal, with a short dropout that must not reach the pin;
      // status clears first so no stale random level is still timing out
      status <= '0;
      wr(REG_SEL0 + 8'h08, 32'(SEL_FAULT));
      wr(REG_DLY0 + 8'h08, 32'h3);
      wr(REG_POL, 32'h0);
      @(posedge clk);
      status.fault_stop <= 1'b1;
      repeat (15) @(posedge clk);
      #1 chk("delay early", term_closed[2], 0);
      repeat (25) @(posedge clk);
      #1 chk("delay done", term_closed[2], 1);
      @(posedge clk);
      status.fault_stop <= 1'b0;
      repeat (5) @(posedge clk);
      status.fault_stop <= 1'b1;
      repeat (45) @(posedge clk);
      #1 chk("dropout held", term_closed[2], 1);
      wr(REG_DLY0 + 8'h08, 32'hFFFF);
      rd(REG_DLY0 + 8'h08);
      chk("delay clip", rv, 32'(DLY_MAX));
      // sequencer cycle pulse width
      wr(REG_SEL0 + 8'h0C, 32'(SEL_SEQ));
      @(posedge clk);
      status.seq_cycle_done <= 1'b1;
      n = 0;
      repeat (50) begin
         @(posedge clk);
         #1 n += int'(term_closed[3]);
      end
      chk("seq pulse", n, SP);
      // pulse mode copies the waveform one cycle late
      wr(REG_MODE, 32'h0);
      #1 chk("pulse mode", fast_terminal_pulse_mode, 1);
      repeat (20) begin
         @(posedge clk);
         pulse_src <= 1'($urandom);
         @(posedge clk);
         #1 chk("pulse pin", term_closed[0], pulse_src);
      end
      finish_test();
   end
endmodule
